// ### core/udm_pkg.sv
package udm_pkg;
  // ----------------------------------------------------------------
  // Operation codes presented to the execution block
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UDM_OP_DIVW,
    UDM_OP_DIVL,
    UDM_OP_ZXB,
    UDM_OP_ZXW,
    UDM_OP_FAR_MOVE,
    UDM_OP_INCW,
    UDM_OP_ADD_ONE_BYTE_OP,
    UDM_OP_TRAP
  } udm_op_t;

  // ----------------------------------------------------------------
  // Cycle counts at 200 MHz (one instruction cycle per clock)
  // ----------------------------------------------------------------
  localparam logic [4:0] UDM_DIV_CYC     = 5'h15;  // 21
  localparam logic [4:0] UDM_DIVW_Z_CYC  = 5'h05;  // 5
  localparam logic [4:0] UDM_DIVL_OV_CYC = 5'h04;  // 4
  localparam logic [4:0] UDM_ONE_CYC     = 5'h01;

  // Flag bit positions in the condition_flags word
  localparam int UDM_F_V = 0;
  localparam int UDM_F_C = 1;
  localparam int UDM_F_N = 2;
  localparam int UDM_F_Z = 3;
  localparam logic [2:0] UDM_LVL_ALL = 3'h7;
  localparam logic [15:0] UDM_SP_STEP = 16'h0002;
  localparam logic [15:0] UDM_VEC0_ADDR = 16'h0000;
  localparam logic [15:0] UDM_ILL_OP = 16'h0000;
endpackage

// ### core/udm_divider.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Restoring divider, one quotient bit per clock
// ------------------------------------------------------------------
module udm_divider #(
  parameter int W = 16
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           start,
  input  wire logic [2*W-1:0] dividend,
  input  wire logic [W-1:0]   divisor,
  output logic                done,
  output logic [W-1:0]        quot,
  output logic [W-1:0]        rem
);
  logic [W:0]   rem_q;
  logic [W-1:0] quo_q;
  logic [W-1:0] dvs_q;
  logic [4:0]   cnt_q;
  logic         busy_q;
  logic [W:0]   trial;
  logic [W:0]   shifted;

  assign shifted = {rem_q[W-1:0], quo_q[W-1]};
  assign trial   = shifted - {1'b0, dvs_q};
  assign quot    = quo_q;
  assign rem     = rem_q[W-1:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rem_q  <= '0;
      quo_q  <= '0;
      dvs_q  <= '0;
      cnt_q  <= 5'h00;
      busy_q <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_q  <= {1'b0, dividend[2*W-1:W]};
        quo_q  <= dividend[W-1:0];
        dvs_q  <= divisor;
        cnt_q  <= 5'(W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        quo_q <= {quo_q[W-2:0], ~trial[W]};
        rem_q <= trial[W] ? shifted : trial;
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule

// ### core/udm_decode.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Invalid opcode detector
// ------------------------------------------------------------------
module udm_decode (
  input  wire logic [15:0] opcode,
  output logic             illegal
);
  logic [7:0] hi;

  assign hi = opcode[15:8];
  assign illegal = (opcode == udm_pkg::UDM_ILL_OP)
                 || (hi >= 8'h6A && hi <= 8'h79)
                 || (hi == 8'h81)
                 || (hi >= 8'h98 && hi <= 8'h9F)
                 || (hi == 8'hEE) || (hi == 8'hEF);
endmodule

// ### core/udm_exec.sv
`timescale 1ns/100ps
// How it works
// - Word divide: dest over source; quotient to dest, rest to high word.
// - Long divide: high word and dest form 32-bit dividend over source.
// - Remainder not written when dest is high word, so quotient is kept.
// - Overflow on zero divisor, or long divisor times 65536 <= dividend.
// - On overflow source, high word and destination stay unmodified.
// - Divide sets carry on quotient overflow, always clears overflow flag.
// - Carry set: Z,N from divisor; carry clear: Z,N from quotient.
// - Word divide takes 21 cycles, 5 when divisor is zero.
// - Long divide takes 21 cycles, 4 on overflow.
// - Byte zero-extend clears upper byte; Z, N=bit7, keep C, clear V.
// - Word zero-extend clears only R1; clears N and V, keeps C.
// - Far pointer bits 15..0 go on address 16..1, address bit 0 low.
// - Plain operand reaches low 64K; pointer reaches full 128K.
// - Far move sets Z, N from data, keeps C, clears V.
// - Trap pushes status, next address plus one; vector 0; level ones.
// - Opcode 0000h and listed opcode bytes raise the trap, flags kept.
// - Word increment sets carry on FFFFh to 0000h wrap.
// - Byte increment yields word in a register, byte store in memory; carry when upper byte is 01h.
// - Increment sets Z, N for its size, V on signed wrap.
module udm_exec (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire udm_pkg::udm_op_t op,
  input  wire logic [15:0]      opcode,
  input  wire logic [15:0]      src_val,
  input  wire logic [15:0]      dst_val,
  input  wire logic [15:0]      high_word_val,
  input  wire logic             dst_is_high,
  input  wire logic             dst_is_mem,
  input  wire logic             far_to_mem,
  input  wire logic [15:0]      far_data_in,
  input  wire logic [15:0]      next_pc,
  input  wire logic [15:0]      stack_pointer,
  input  wire logic [15:0]      condition_flags,
  input  wire logic [15:0]      vector_data,
  output logic                  busy,
  output logic                  done,
  output logic                  dst_we,
  output logic [15:0]           dst_wdata,
  output logic                  high_we,
  output logic [15:0]           high_wdata,
  output logic                  mem_we,
  output logic                  mem_re,
  output logic                  mem_byte,
  output logic [16:0]           mem_addr,
  output logic [15:0]           mem_wdata,
  output logic                  flags_we,
  output logic [3:0]            flags_out,
  output logic                  sp_we,
  output logic [15:0]           sp_wdata,
  output logic                  pc_we,
  output logic [15:0]           pc_wdata,
  output logic                  level_we,
  output logic [2:0]            interrupt_level_bits
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UDM_IDLE, UDM_DIV, UDM_WAIT, UDM_PUSH2, UDM_VEC, UDM_FIN
  } udm_state_t;

  udm_state_t       st_q;
  udm_pkg::udm_op_t op_q;
  logic [4:0]       cyc_q;
  logic [4:0]       len_q;
  logic [15:0]      src_q;
  logic [15:0]      sp_q;
  logic [15:0]      pc_q;
  logic [3:0]       fl_q;
  logic             ovf_q;
  logic             dih_q;

  logic             is_ill;
  logic             div_start;
  logic             div_done;
  logic [15:0]      div_quot;
  logic [15:0]      div_rem;
  logic             is_long;
  logic [31:0]      dividend;
  logic             ovf_now;
  logic [16:0]      inc_w;
  logic [15:0]      inc_b;
  logic [15:0]      zxb;
  logic [16:0]      far_addr;

  udm_decode u_dec (
    .opcode  (opcode),
    .illegal (is_ill)
  );

  // Long form: high word above destination
  assign is_long  = (op == udm_pkg::UDM_OP_DIVL);
  assign dividend = is_long ? {high_word_val, dst_val}
                            : {16'h0000, dst_val};
  // Divisor times 65536 <= dividend is simply divisor <= high word
  assign ovf_now  = (src_val == 16'h0000)
                  || (is_long && src_val <= high_word_val);
  // A start while busy must not restart the divider under a running op
  assign div_start = start && st_q == UDM_IDLE && !is_ill && !ovf_now
                   && (op == udm_pkg::UDM_OP_DIVW || is_long);

  udm_divider #(.W(16)) u_div (
    .clk      (clk),
    .rst_b    (rst_b),
    .start    (div_start),
    .dividend (dividend),
    .divisor  (src_val),
    .done     (div_done),
    .quot     (div_quot),
    .rem      (div_rem)
  );

  assign inc_w    = {1'b0, dst_val} + 17'h00001;
  assign inc_b    = {8'h00, dst_val[7:0]} + 16'h0001;
  assign zxb      = {8'h00, dst_val[7:0]};
  assign far_addr = {dst_val, 1'b0};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= UDM_IDLE;
      op_q  <= udm_pkg::UDM_OP_DIVW;
      cyc_q <= 5'h00;
      len_q <= 5'h00;
      src_q <= 16'h0000;
      sp_q  <= 16'h0000;
      pc_q  <= 16'h0000;
      fl_q  <= 4'h0;
      ovf_q <= 1'b0;
      dih_q <= 1'b0;
      busy  <= 1'b0;
      done  <= 1'b0;
      dst_we <= 1'b0;
      dst_wdata <= 16'h0000;
      high_we <= 1'b0;
      high_wdata <= 16'h0000;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= 17'h00000;
      mem_wdata <= 16'h0000;
      flags_we <= 1'b0;
      flags_out <= 4'h0;
      sp_we <= 1'b0;
      sp_wdata <= 16'h0000;
      pc_we <= 1'b0;
      pc_wdata <= 16'h0000;
      level_we <= 1'b0;
      interrupt_level_bits <= 3'h0;
    end else begin
      done <= 1'b0;
      dst_we <= 1'b0;
      high_we <= 1'b0;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_byte <= 1'b0;
      flags_we <= 1'b0;
      sp_we <= 1'b0;
      pc_we <= 1'b0;
      level_we <= 1'b0;
      cyc_q <= cyc_q + 5'h01;
      unique case (st_q)
        UDM_IDLE: begin
          cyc_q <= 5'h01;
          fl_q  <= condition_flags[3:0];
          src_q <= src_val;
          sp_q  <= stack_pointer;
          pc_q  <= next_pc;
          dih_q <= dst_is_high;
          if (start) begin
            busy <= 1'b1;
            op_q <= is_ill ? udm_pkg::UDM_OP_TRAP : op;
            if (is_ill || op == udm_pkg::UDM_OP_TRAP) begin
              // First push: status word
              mem_we    <= 1'b1;
              mem_addr  <= {stack_pointer, 1'b0};
              mem_wdata <= condition_flags;
              st_q      <= UDM_PUSH2;
            end else if (op == udm_pkg::UDM_OP_DIVW || is_long) begin
              ovf_q <= ovf_now;
              len_q <= !ovf_now ? udm_pkg::UDM_DIV_CYC
                     : is_long ? udm_pkg::UDM_DIVL_OV_CYC
                     : udm_pkg::UDM_DIVW_Z_CYC;
              st_q  <= ovf_now ? UDM_WAIT : UDM_DIV;
            end else begin
              len_q <= udm_pkg::UDM_ONE_CYC;
              st_q  <= UDM_FIN;
              if (op == udm_pkg::UDM_OP_FAR_MOVE) begin
                // Pointer reaches 128K, plain side stays in low 64K
                mem_addr  <= far_addr;
                mem_we    <= far_to_mem;
                mem_re    <= !far_to_mem;
                mem_wdata <= src_val;
              end
            end
          end
        end
        UDM_DIV: begin
          if (div_done) begin
            st_q <= UDM_WAIT;
          end
        end
        UDM_WAIT: begin
          // FIN raises done one edge later, so leave two counts early
          if (cyc_q >= len_q - 5'h02) begin
            st_q <= UDM_FIN;
          end
        end
        UDM_PUSH2: begin
          mem_we    <= 1'b1;
          mem_addr  <= {sp_q + udm_pkg::UDM_SP_STEP, 1'b0};
          mem_wdata <= pc_q + 16'h0001;
          mem_re    <= 1'b0;
          st_q      <= UDM_VEC;
        end
        UDM_VEC: begin
          mem_re   <= 1'b1;
          mem_addr <= {udm_pkg::UDM_VEC0_ADDR, 1'b0};
          st_q     <= UDM_FIN;
        end
        UDM_FIN: begin
          busy <= 1'b0;
          done <= 1'b1;
          st_q <= UDM_IDLE;
          unique case (op_q)
            udm_pkg::UDM_OP_DIVW, udm_pkg::UDM_OP_DIVL: begin
              // Only commit point of a divide
              flags_we <= 1'b1;
              flags_out[udm_pkg::UDM_F_V] <= 1'b0;
              flags_out[udm_pkg::UDM_F_C] <= ovf_q;
              flags_out[udm_pkg::UDM_F_Z] <= ovf_q
                ? (src_q == 16'h0000) : (div_quot == 16'h0000);
              flags_out[udm_pkg::UDM_F_N] <= ovf_q
                ? src_q[15] : div_quot[15];
              high_we    <= !ovf_q && !dih_q;
              high_wdata <= div_rem;
              dst_we     <= !ovf_q;
              dst_wdata  <= div_quot;
            end
            udm_pkg::UDM_OP_ZXB: begin
              dst_we    <= 1'b1;
              dst_wdata <= zxb;
              flags_we  <= 1'b1;
              flags_out <= {zxb == 16'h0000, zxb[7],
                            fl_q[udm_pkg::UDM_F_C], 1'b0};
            end
            udm_pkg::UDM_OP_ZXW: begin
              high_we    <= 1'b1;
              high_wdata <= 16'h0000;
              flags_we   <= 1'b1;
              flags_out  <= {1'b1, 1'b0,
                             fl_q[udm_pkg::UDM_F_C], 1'b0};
            end
            udm_pkg::UDM_OP_FAR_MOVE: begin
              dst_we    <= !mem_we;
              dst_wdata <= far_data_in;
              flags_we  <= 1'b1;
              flags_out <= mem_we
                ? {mem_wdata == 16'h0000, mem_wdata[15],
                   fl_q[udm_pkg::UDM_F_C], 1'b0}
                : {far_data_in == 16'h0000, far_data_in[15],
                   fl_q[udm_pkg::UDM_F_C], 1'b0};
            end
            udm_pkg::UDM_OP_INCW: begin
              dst_we    <= !dst_is_mem;
              mem_we    <= dst_is_mem;
              mem_byte  <= 1'b0;
              dst_wdata <= inc_w[15:0];
              mem_wdata <= inc_w[15:0];
              flags_we  <= 1'b1;
              flags_out <= {inc_w[15:0] == 16'h0000, inc_w[15],
                            inc_w[16],
                            dst_val == 16'h7FFF};
            end
            udm_pkg::UDM_OP_ADD_ONE_BYTE_OP: begin
              dst_we    <= !dst_is_mem;
              mem_we    <= dst_is_mem;
              mem_byte  <= dst_is_mem;
              dst_wdata <= inc_b;
              mem_wdata <= {8'h00, inc_b[7:0]};
              flags_we  <= 1'b1;
              flags_out <= {inc_b[7:0] == 8'h00, inc_b[7],
                            inc_b[8],
                            dst_val[7:0] == 8'h7F};
            end
            udm_pkg::UDM_OP_TRAP: begin
              // Flags untouched; vector 0 loads PC
              sp_we    <= 1'b1;
              sp_wdata <= sp_q + udm_pkg::UDM_SP_STEP
                          + udm_pkg::UDM_SP_STEP;
              pc_we    <= 1'b1;
              pc_wdata <= vector_data;
              level_we <= 1'b1;
              interrupt_level_bits <= udm_pkg::UDM_LVL_ALL;
            end
          endcase
        end
        default: st_q <= UDM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  div_ovf_keep_a: assert property (done && op_q == udm_pkg::UDM_OP_DIVW
      && ovf_q |-> !dst_we && !high_we)
    else $error("overflowed divide wrote a register");
  div_v_clr_a: assert property (flags_we && (op_q == udm_pkg::UDM_OP_DIVW
      || op_q == udm_pkg::UDM_OP_DIVL) |-> !flags_out[0])
    else $error("divide left V set");
  div_word_len_a: assert property (start && st_q == UDM_IDLE && !is_ill
      && op == udm_pkg::UDM_OP_DIVW && src_val != 16'h0000
      |-> ##21 done)
    else $error("word divide not 21 cycles");
  div_zero_len_a: assert property (start && st_q == UDM_IDLE && !is_ill
      && op == udm_pkg::UDM_OP_DIVW && src_val == 16'h0000
      |-> ##5 done)
    else $error("zero divisor not 5 cycles");
  divl_ovf_len_a: assert property (start && st_q == UDM_IDLE && !is_ill
      && is_long && ovf_now |-> ##4 done)
    else $error("long overflow not 4 cycles");
  trap_level_a: assert property (level_we |->
      interrupt_level_bits == 3'h7 && pc_we && !flags_we)
    else $error("trap level or flags wrong");
  sequence trap_push_s;
    mem_we ##1 mem_we;
  endsequence

  illegal_trap_a: assert property (start && st_q == UDM_IDLE && is_ill
      |-> ##1 trap_push_s ##2 level_we)
    else $error("illegal opcode did not trap");
  far_addr_a: assert property (st_q == UDM_IDLE && start && !is_ill
      && op == udm_pkg::UDM_OP_FAR_MOVE |=> !mem_addr[0])
    else $error("far address bit 0 not low");
endmodule

// ### tb/unsigned_divide_misc_ops_bench.sv
`timescale 1ns/100ps
module unsigned_divide_misc_ops_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic             clk, rst_b, start, dst_is_high, dst_is_mem, far_to_mem;
  udm_pkg::udm_op_t op;
  logic [15:0]      opcode, src_val, dst_val, high_word_val, far_data_in;
  logic [15:0]      next_pc, stack_pointer, condition_flags, vector_data;
  logic             busy, done, dst_we, high_we, mem_we, mem_re, mem_byte;
  logic             flags_we, sp_we, pc_we, level_we;
  logic [15:0]      dst_wdata, high_wdata, mem_wdata, sp_wdata, pc_wdata;
  logic [16:0]      mem_addr;
  logic [3:0]       flags_out;
  logic [2:0]       interrupt_level_bits;
  logic [16:0]      e_dst, o_dst, e_hi, o_hi, e_sp, o_sp, e_pc, o_pc;
  logic [17:0]      e_rd, o_rd;
  logic [4:0]       e_flg, o_flg;
  logic [3:0]       e_lvl, o_lvl;
  logic [33:0]      e_mem[$], o_mem[$], mmask;
  logic             o_early, o_busy, poke;
  int               e_cyc, o_cyc, error_cnt, cmp_count;

  udm_exec u_dut (
    .clk(clk), .rst_b(rst_b), .start(start), .op(op), .opcode(opcode),
    .src_val(src_val), .dst_val(dst_val), .high_word_val(high_word_val),
    .dst_is_high(dst_is_high), .dst_is_mem(dst_is_mem),
    .far_to_mem(far_to_mem), .far_data_in(far_data_in),
    .next_pc(next_pc), .stack_pointer(stack_pointer),
    .condition_flags(condition_flags), .vector_data(vector_data),
    .busy(busy), .done(done), .dst_we(dst_we), .dst_wdata(dst_wdata),
    .high_we(high_we), .high_wdata(high_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_byte(mem_byte), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .flags_we(flags_we), .flags_out(flags_out),
    .sp_we(sp_we), .sp_wdata(sp_wdata), .pc_we(pc_we),
    .pc_wdata(pc_wdata), .level_we(level_we),
    .interrupt_level_bits(interrupt_level_bits)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [35:0] e, logic [35:0] o);
    cmp_count++;
    if (e !== o) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, o);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reference model: flags word is {written, Z, N, C, V}
  task automatic model();
    logic [31:0] dd;
    logic [16:0] r;
    logic [15:0] d;
    logic [7:0]  hb;
    logic        cf;
    hb = opcode[15:8];
    cf = condition_flags[udm_pkg::UDM_F_C];
    {e_dst, e_hi, e_sp, e_pc, e_rd, e_flg, e_lvl} = '0;
    e_mem.delete();
    mmask = '1;
    e_cyc = 2;
    if (opcode == 16'h0000 || (hb >= 8'h6A && hb <= 8'h79) || hb == 8'h81
        || (hb >= 8'h98 && hb <= 8'h9F) || hb == 8'hEE || hb == 8'hEF
        || op == udm_pkg::UDM_OP_TRAP) begin
      e_cyc = 4;
      e_mem.push_back({1'b0, stack_pointer, 1'b0, condition_flags});
      e_mem.push_back({1'b0, stack_pointer + 16'h0002, 1'b0,
                       next_pc + 16'h0001});
      e_rd  = {1'b1, 17'h00000};
      e_sp  = {1'b1, stack_pointer + 16'h0004};
      e_pc  = {1'b1, vector_data};
      e_lvl = {1'b1, 3'h7};
    end else case (op)
      udm_pkg::UDM_OP_DIVW, udm_pkg::UDM_OP_DIVL: begin
        dd = {16'h0000, dst_val};
        if (op == udm_pkg::UDM_OP_DIVL) dd = {high_word_val, dst_val};
        if ({src_val, 16'h0000} <= dd) begin
          e_cyc = (op == udm_pkg::UDM_OP_DIVW) ? 5 : 4;
          e_flg = {1'b1, src_val == 16'h0000, src_val[15], 2'b10};
        end else begin
          e_cyc = 21;
          d     = 16'(dd / src_val);
          e_flg = {1'b1, d == 16'h0000, d[15], 2'b00};
          e_dst = {1'b1, d};
          if (!dst_is_high) e_hi = {1'b1, 16'(dd % src_val)};
        end
      end
      udm_pkg::UDM_OP_ZXB: begin
        e_dst = {9'h100, dst_val[7:0]};
        e_flg = {1'b1, dst_val[7:0] == 8'h00, dst_val[7], cf, 1'b0};
      end
      udm_pkg::UDM_OP_ZXW: begin
        e_hi  = {1'b1, 16'h0000};
        e_flg = {3'b110, cf, 1'b0};
      end
      udm_pkg::UDM_OP_FAR_MOVE: begin
        d = far_to_mem ? src_val : far_data_in;
        if (far_to_mem) e_mem.push_back({1'b0, dst_val, 1'b0, src_val});
        else begin
          e_rd  = {1'b1, dst_val, 1'b0};
          e_dst = {1'b1, far_data_in};
        end
        e_flg = {1'b1, d == 16'h0000, d[15], cf, 1'b0};
      end
      default: begin
        if (op == udm_pkg::UDM_OP_INCW) begin
          r     = {1'b0, dst_val} + 17'h00001;
          e_flg = {1'b1, r[15:0] == 16'h0000, r[15], r[16],
                   dst_val == 16'h7FFF};
        end else begin
          r     = {9'h000, dst_val[7:0]} + 17'h00001;
          e_flg = {1'b1, r[7:0] == 8'h00, r[7], r[8], dst_val[7:0] == 8'h7F};
        end
        if (!dst_is_mem) e_dst = {1'b1, r[15:0]};
        else begin
          // Store address is not modelled, only size and data
          mmask = {1'b1, 17'h00000, 16'hFFFF};
          if (op == udm_pkg::UDM_OP_ADD_ONE_BYTE_OP) mmask[15:8] = 8'h00;
          e_mem.push_back({op == udm_pkg::UDM_OP_ADD_ONE_BYTE_OP, 17'h00000, r[15:0]});
        end
      end
    endcase
  endtask

  // One operation, launched at a falling edge, observed until done
  task automatic go(udm_pkg::udm_op_t o, logic [15:0] s, d, h);
    int n;
    op = o;
    src_val = s;
    dst_val = d;
    high_word_val = h;
    model();
    {o_dst, o_hi, o_sp, o_pc, o_rd, o_flg, o_lvl, o_early, o_busy} = '0;
    o_mem.delete();
    start = 1'b1;
    for (n = 1; n <= 40; n++) begin
      @(negedge clk);
      if (n == 1) o_busy = busy;
      if (dst_we) o_dst = {1'b1, dst_wdata};
      if (high_we) o_hi = {1'b1, high_wdata};
      if (flags_we) o_flg = {1'b1, flags_out};
      if (sp_we) o_sp = {1'b1, sp_wdata};
      if (pc_we) o_pc = {1'b1, pc_wdata};
      if (level_we) o_lvl = {1'b1, interrupt_level_bits};
      if (mem_re) o_rd = {1'b1, mem_addr};
      if (mem_we) o_mem.push_back({mem_byte, mem_addr, mem_wdata});
      if ((dst_we || high_we || flags_we) && done !== 1'b1) o_early = 1'b1;
      if (done === 1'b1) break;
      // A start raised mid-operation must be ignored
      start = poke && n == 3;
    end
    o_cyc = n;
    chk("cycles", 36'(e_cyc), 36'(o_cyc));
    chk("busy", 36'h1, {35'h0, o_busy});
    chk("early_write", 36'h0, {35'h0, o_early});
    chk("dst", 36'(e_dst), 36'(o_dst));
    chk("high", 36'(e_hi), 36'(o_hi));
    chk("flags", 36'(e_flg), 36'(o_flg));
    chk("sp", 36'(e_sp), 36'(o_sp));
    chk("pc", 36'(e_pc), 36'(o_pc));
    chk("level", 36'(e_lvl), 36'(o_lvl));
    chk("read", 36'(e_rd), 36'(o_rd));
    chk("mem_count", 36'(e_mem.size()), 36'(o_mem.size()));
    foreach (o_mem[i]) begin
      if (i < e_mem.size()) begin
        chk("mem", 36'(e_mem[i] & mmask), 36'(o_mem[i] & mmask));
      end
    end
  endtask

  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] s, h;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(32'h5a3b));
    {start, dst_is_high, dst_is_mem, far_to_mem, poke} = '0;
    rst_b = 1'b0;
    op = udm_pkg::UDM_OP_INCW;
    opcode = 16'hA000;
    {src_val, dst_val, high_word_val, far_data_in} = '0;
    next_pc = 16'h2468;
    stack_pointer = 16'h0F00;
    condition_flags = 16'h0000;
    vector_data = 16'h0100;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("reset_out", 36'h0, 36'({busy, done, dst_we, high_we, mem_we,
        mem_re, flags_we, sp_we, pc_we, level_we}));
    rst_b = 1'b1;
    go(udm_pkg::UDM_OP_DIVW, 16'h0000, 16'h1234, 16'h5555);
    go(udm_pkg::UDM_OP_DIVW, 16'h0007, 16'hFFFF, 16'h1111);
    go(udm_pkg::UDM_OP_DIVW, 16'h0009, 16'h0005, 16'h1111);
    dst_is_high = 1'b1;
    go(udm_pkg::UDM_OP_DIVW, 16'h0003, 16'h8001, 16'h8001);
    poke = 1'b1;
    go(udm_pkg::UDM_OP_DIVL, 16'h0002, 16'h0000, 16'h0001);
    dst_is_high = 1'b0;
    go(udm_pkg::UDM_OP_DIVL, 16'h1235, 16'hFFFF, 16'h1234);
    poke = 1'b0;
    go(udm_pkg::UDM_OP_DIVL, 16'h8000, 16'h0000, 16'h8000);
    go(udm_pkg::UDM_OP_DIVL, 16'h0000, 16'h0001, 16'h0000);
    go(udm_pkg::UDM_OP_DIVL, 16'h1234, 16'h0000, 16'h1234);
    for (int k = 0; k < 40; k++) begin
      dst_is_high = k[2];
      condition_flags = 16'($urandom);
      s = 16'($urandom);
      h = 16'($urandom) % (s | 16'h0001);
      go(k[0] ? udm_pkg::UDM_OP_DIVL : udm_pkg::UDM_OP_DIVW, s,
         16'($urandom), h);
    end
    dst_is_high = 1'b0;
    $display("test divide done");
    for (int c = 0; c < 2; c++) begin
      condition_flags = c[0] ? 16'h0002 : 16'h0001;
      go(udm_pkg::UDM_OP_ZXB, 16'h0000, 16'h1280, 16'h7777);
      go(udm_pkg::UDM_OP_ZXB, 16'h0000, 16'hAB00, 16'h7777);
      go(udm_pkg::UDM_OP_ZXW, 16'h0000, 16'h9876, 16'h7777);
      far_to_mem = 1'b1;
      go(udm_pkg::UDM_OP_FAR_MOVE, 16'h0000, 16'hE200, 16'h0000);
      go(udm_pkg::UDM_OP_FAR_MOVE, 16'h8000, 16'hFFFF, 16'h0000);
      far_to_mem = 1'b0;
      far_data_in = 16'h8001;
      go(udm_pkg::UDM_OP_FAR_MOVE, 16'h0040, 16'h8000, 16'h0000);
    end
    $display("test extend and far move done");
    go(udm_pkg::UDM_OP_INCW, 16'h0000, 16'hFFFF, 16'h0000);
    go(udm_pkg::UDM_OP_INCW, 16'h0000, 16'h7FFF, 16'h0000);
    go(udm_pkg::UDM_OP_ADD_ONE_BYTE_OP, 16'h0000, 16'h12FF, 16'h0000);
    go(udm_pkg::UDM_OP_ADD_ONE_BYTE_OP, 16'h0000, 16'h347F, 16'h0000);
    dst_is_mem = 1'b1;
    go(udm_pkg::UDM_OP_ADD_ONE_BYTE_OP, 16'h0000, 16'h55FF, 16'h0000);
    go(udm_pkg::UDM_OP_INCW, 16'h0000, 16'h7FFF, 16'h0000);
    dst_is_mem = 1'b0;
    $display("test increment done");
    for (int k = 0; k < 257; k++) begin
      opcode = (k == 256) ? 16'h0000 : {k[7:0], 8'h11};
      stack_pointer = 16'($urandom);
      next_pc = 16'($urandom);
      vector_data = 16'($urandom);
      go(udm_pkg::UDM_OP_INCW, 16'h0000, 16'h4321, 16'h0000);
    end
    opcode = 16'hA000;
    go(udm_pkg::UDM_OP_TRAP, 16'h0000, 16'h0000, 16'h0000);
    $display("test trap done");
    tally_and_finish();
  end
endmodule
